// ### bench/haptic_playback_mode_control_test.sv
/* haptic_playback_mode_control_test: self-checking bench for hpm_ctrl against an
   integer model. assumes hpm_pkg and the pwm source model on the stream pin. */
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module haptic_playback_mode_control_test;
    import hpm_pkg::*;
    logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_boot_done = 1'b0;
    logic i_fault = 1'b0, i_zero_cross = 1'b0, i_playback_done = 1'b0, run = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00, i_mem_level = 8'h00, per = 8'h10, high = 8'h04;
    logic [7:0] o_rdata, o_drive_mag, rdata, exp_mag, nom, absv, code, duty, exp_st;
    logic pin, o_drive_reverse, o_stage_en, o_bridge_tick, o_half_pol, o_mem_start;
    logic acc, hp, ce = 1'b1;
    hpm_state_t o_state;
    int fail_count = 0, checks_done = 0, stage_on = 0, k;
    logic [3:0] ra [6] = '{ADDR_CTRL, ADDR_STREAM, ADDR_NOMMAX, ADDR_ABSMAX,
        ADDR_MIN_DUTY, 4'hF};
    logic [7:0] rv [6] = '{8'h00, RST_STREAM, RST_NOMMAX, RST_ABSMAX, RST_MIN_DUTY, 8'h00};
    logic [7:0] cs [4] = '{8'h7F, 8'h7F, 8'h80, 8'h80};
    logic [7:0] hs [2] = '{8'h02, 8'h08};

    hpm_ctrl hpm_ctrl_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_trigger_stream_pin(pin), .i_boot_done(i_boot_done), .i_fault(i_fault),
        .i_zero_cross(i_zero_cross), .i_playback_done(i_playback_done),
        .i_mem_level(i_mem_level), .o_state(o_state), .o_drive_mag(o_drive_mag),
        .o_drive_reverse(o_drive_reverse), .o_stage_en(o_stage_en),
        .o_bridge_tick(o_bridge_tick), .o_half_pol(o_half_pol), .o_mem_start(o_mem_start));
    hpm_pwm_src hpm_pwm_src_inst (.i_run(run), .i_period(per), .i_high(high), .o_pin(pin));

    initial begin
        forever #10 i_clk = ~i_clk;
    end

    // every task returns 1 ns after an edge, so outputs are settled when read
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask : rd
    task automatic pls(input logic dn);
        @(posedge i_clk);
        i_zero_cross <= !dn;
        i_playback_done <= dn;
        @(posedge i_clk);
        i_zero_cross <= 1'b0;
        i_playback_done <= 1'b0;
        cyc(2);
    endtask : pls
    function automatic logic [7:0] ctl(input logic [2:0] m, input logic a, input logic s);
        return {3'h0, s, a, m};
    endfunction : ctl
    // signed codes fold to magnitude; 0x7F is taken as exactly full scale
    function automatic logic [7:0] emag(input logic [7:0] c, input logic a,
        input logic [7:0] vn, input logic [7:0] va);
        int m;
        int v;
        m = a ? (c[7] ? 0 : int'(c)) : (c[7] ? 256 - int'(c) : int'(c));
        v = a ? int'(vn) : int'(va);
        return (m >= 127) ? v[7:0] : 8'((m * v) >> 7);
    endfunction : emag
    task automatic final_report;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        #400000;
        fail_count++;
        final_report();
    end

    initial begin
        void'($urandom(32'h7748));
        // maxima at or above 0x80 keep every nonzero code a nonzero magnitude
        nom = 8'h80 | 8'($urandom);
        absv = 8'h80 | 8'($urandom);
        i_mem_level <= 8'($urandom);
        exp_mag = 8'h00;
        cyc(20);
        i_rst <= 1'b0;
        `CHK(o_state, HPM_BOOT)
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], rdata);
            `CHK(rdata, rv[i])
        end
        i_boot_done <= 1'b1;
        cyc(3);
        `CHK(o_state, HPM_IDLE)
        wr(ADDR_NOMMAX, nom);
        wr(ADDR_ABSMAX, absv);
        wr(ADDR_STREAM, 8'h00);
        wr(ADDR_CTRL, ctl(MODE_REG_STREAM, 1'b1, 1'b0));
        cyc(3);
        `CHK(o_state, HPM_DRIVE)
        for (int i = 0; i < 14; i++) begin
            code = (i < 4) ? cs[i] : 8'($urandom);
            acc = (i < 4) ? i[0] : 1'($urandom);
            wr(ADDR_CTRL, ctl(MODE_REG_STREAM, acc, 1'b0));
            wr(ADDR_STREAM, code);
            cyc(3);
            `CHK(o_drive_mag, exp_mag)
            exp_mag = emag(code, acc, nom, absv);
            hp = o_half_pol;
            pls(1'b0);
            `CHK(o_half_pol, ~hp)
            if (exp_mag == 0 || stage_on == 0) `CHK(o_stage_en, 1'b0)
            pls(1'b0);
            `CHK(o_drive_mag, exp_mag)
            `CHK(o_stage_en, exp_mag != 0)
            if (exp_mag != 0) `CHK(o_drive_reverse, !acc && code[7])
            stage_on = (exp_mag != 0);
            exp_st = {4'h0, (exp_mag != 8'h00), hp, 2'(HPM_DRIVE)};
            rd(ADDR_STATUS, rdata);
            `CHK(rdata, exp_st)
            rd(ADDR_LEVEL, rdata);
            `CHK(rdata, exp_mag)
        end
        // a zero cross with the clock enable low must leave every output frozen
        ce <= 1'b0;
        pls(1'b0);
        `CHK(o_half_pol, hp)
        `CHK(o_drive_mag, exp_mag)
        ce <= 1'b1;
        wr(ADDR_STREAM, 8'h40);
        pls(1'b0);
        pls(1'b0);
        for (k = 0; k < 300 && o_bridge_tick !== 1'b1; k++) cyc(1);
        cyc(1);
        for (k = 1; k < 300 && o_bridge_tick !== 1'b1; k++) cyc(1);
        `CHK(k, 266)
        @(posedge i_clk);
        i_fault <= 1'b1;
        cyc(2);
        `CHK(o_state, HPM_IDLE)
        cyc(5);
        `CHK(o_state, HPM_IDLE)
        `CHK(o_stage_en, 1'b0)
        `CHK(o_drive_mag, 8'h00)
        i_fault <= 1'b0;
        cyc(4);
        `CHK(o_state, HPM_DRIVE)
        wr(ADDR_CTRL, ctl(MODE_INACTIVE, 1'b0, 1'b0));
        cyc(3);
        `CHK(o_state, HPM_IDLE)
        wr(ADDR_CTRL, ctl(MODE_REG_STREAM, 1'b0, 1'b1));
        wr(ADDR_CTRL, ctl(MODE_INACTIVE, 1'b0, 1'b1));
        cyc(3);
        `CHK(o_state, HPM_STANDBY)
        for (int m = 5; m < 8; m++) begin
            wr(ADDR_CTRL, ctl(3'(m), 1'b0, 1'b1));
            wr(ADDR_TRIGGER, 8'h01);
            cyc(3);
            `CHK(o_state, HPM_STANDBY)
        end
        wr(ADDR_CTRL, ctl(MODE_WRITE_MEM, 1'b0, 1'b0));
        run <= 1'b1;
        cyc(300);
        `CHK(o_state, HPM_STANDBY)
        wr(ADDR_TRIGGER, 8'h01);
        for (k = 0; k < 10 && o_mem_start !== 1'b1; k++) cyc(1);
        `CHK(o_mem_start, 1'b1)
        `CHK(o_state, HPM_DRIVE)
        pls(1'b0);
        pls(1'b0);
        `CHK(o_drive_mag, emag(i_mem_level, 1'b0, nom, absv))
        pls(1'b1);
        `CHK(o_state, HPM_IDLE)
        wr(ADDR_CTRL, ctl(MODE_EDGE_MEM, 1'b0, 1'b0));
        for (k = 0; k < 200 && o_mem_start !== 1'b1; k++) cyc(1);
        run <= 1'b0;
        `CHK(o_state, HPM_DRIVE)
        pls(1'b1);
        `CHK(o_state, HPM_IDLE)
        wr(ADDR_CTRL, ctl(MODE_INACTIVE, 1'b0, 1'b0));
        wr(ADDR_MIN_DUTY, 8'h40);
        for (int i = 0; i < 7; i++) begin
            high <= (i < 2) ? hs[i] : 8'($urandom_range(15, 1));
            acc = (i == 1) ? 1'b0 : 1'($urandom);
            run <= 1'b1;
            cyc(400);
            wr(ADDR_CTRL, ctl(MODE_PWM_STREAM, acc, 1'b0));
            duty = {high[3:0], 4'h0};
            code = (duty < 8'h40) ? 8'h00 : (acc ? {1'b0, duty[7:1]} : duty ^ 8'h80);
            exp_mag = emag(code, acc, nom, absv);
            pls(1'b0);
            pls(1'b0);
            `CHK(o_drive_mag, exp_mag)
            `CHK(o_stage_en, exp_mag != 0)
            rd(ADDR_DUTY, rdata);
            `CHK(rdata, duty)
        end
        final_report();
    end
endmodule : haptic_playback_mode_control_test

// ### bench/hpm_pwm_src.sv
/* hpm_pwm_src: pwm source that stands on the trigger/stream pin.
   assumes period and high time in 160 ns link steps, changed only while idle
   or accepted with one distorted period. */
`timescale 1ns/10ps
module hpm_pwm_src (
    input wire logic i_run, // run the source
    input wire logic [7:0] i_period, // period in 160 ns steps
    input wire logic [7:0] i_high, // high time in 160 ns steps
    output logic o_pin // trigger/stream pin
);
    initial begin
        o_pin = 1'b0;
        // odd offset keeps pin edges away from the sampling clock edge
        #3;
        forever begin
            if (i_run) begin
                o_pin = 1'b1;
                #(i_high * 160);
                o_pin = 1'b0;
                #((i_period - i_high) * 160);
            end else begin
                o_pin = 1'b0;
                #160;
            end
        end
    end
endmodule : hpm_pwm_src

// ### rtl/hpm_ctrl.sv
/*
 * hpm_ctrl: system state machine, operating-mode selection and streamed drive-level
 * logic (register streaming and PWM demodulation) of a haptic actuator driver.
 * Assumes: fault flags, zero-cross pulses, memory playback level and done come from
 * logic on i_clk; the trigger/stream pin is asynchronous and is synchronised here.
 */
`timescale 1ns/10ps

// Operation
// - after reset load defaults, then wait in idle once boot completes.
// - any fault sends the device straight to idle; the code ignores faults while in boot.
// - playback start moves the device from idle or standby into the drive state.
// - playback end returns to standby if enabled, else idle.
// - mode field: 0 off, 1 register, 2 pwm, 3 write-trigger, 4 edge-trigger.
// - inactive keeps registers; start needs a request and no fault flags.
// - register streaming drives from the streamed drive level register.
// - assist on: codes 0x00..0x7F scale nominal max, 0x80..0xFF unused.
// - steady-state level scales to nominal max while assist is on.
// - assist off: signed code scales absolute max, 0x80 -100, 0x7F +100.
// - negative level reverses polarity or shifts actuator phase by 180 degrees.
// - amplitude updates only at zero crossings, sampling the requested level.
// - new level may lag one half-period; polarity indication aids alignment.
// - register streaming at zero disables stage; nonzero re-enables half-period later.
// - pwm mode derives level from pin duty; source should run first.
// - pwm with assist on maps duty to 0..100 percent nominal.
// - pwm with assist off maps duty to signed absolute, 50 percent zero.
// - output bridge switches at 187.5 kHz regardless of input frequency; the 266-clock divider here gives about 188.0 kHz.
// - duty demodulator measures on rising input edges.
// - duty below the minimum duty threshold yields zero drive.
// - pwm zero level disables stage; re-enable one half-period after nonzero.
// - register port stays fully operational in every state.
module hpm_ctrl #(
    parameter int CNT_W = 16
) (
    input wire logic i_clk, // system clock
    input wire logic i_rst, // synchronous reset, active high
    input wire logic i_ce, // clock enable, freezes all state when low
    input wire logic [hpm_pkg::REG_AW-1:0] i_addr, // register address
    input wire logic [hpm_pkg::REG_DW-1:0] i_wdata, // register write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [hpm_pkg::REG_DW-1:0] o_rdata, // read data, cycle after strobe
    input wire logic i_trigger_stream_pin, // asynchronous trigger/stream pin
    input wire logic i_boot_done, // boot sequence complete
    input wire logic i_fault, // any fault flag still set
    input wire logic i_zero_cross, // pulse at actuator voltage zero cross
    input wire logic i_playback_done, // memory sequence finished
    input wire logic [7:0] i_mem_level, // level code from memory sequencer
    output hpm_pkg::hpm_state_t o_state, // system state
    output logic [7:0] o_drive_mag, // applied drive magnitude
    output logic o_drive_reverse, // reverse polarity / 180 degree phase
    output logic o_stage_en, // output stage enable
    output logic o_bridge_tick, // bridge switching strobe
    output logic o_half_pol, // half-period polarity indication
    output logic o_mem_start // pulse: start memory playback
);
    import hpm_pkg::*;

    typedef struct packed {
        hpm_state_t fsm;
        logic [2:0] mode;
        logic accel;
        logic standby;
        logic lra;
        logic [7:0] stream;
        logic [7:0] nommax;
        logic [7:0] absmax;
        logic [7:0] min_duty;
        logic [7:0] rdata;
        logic pin_s1;
        logic pin_s2;
        logic pin_q;
        logic [CNT_W-1:0] per_cnt;
        logic [CNT_W-1:0] hi_cnt;
        logic [7:0] duty;
        logic [7:0] app_mag;
        logic app_neg;
        logic stage_en;
        logic en_pend;
        logic half_pol;
        logic [8:0] br_cnt;
        logic br_tick;
        logic mem_active;
        logic mem_start;
    } hpm_regs_t;

    localparam logic [8:0] BR_LAST = 9'(BRIDGE_DIV - 1);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    hpm_regs_t q_r;
    hpm_regs_t q_nxt;

    // magnitude 0..128 scaled against a full-scale voltage code
    function automatic logic [7:0] hpm_scale(input logic [7:0] m, input logic [7:0] volt);
        logic [15:0] p;
        p = 16'(m) * 16'(volt);
        if (m >= CODE_FULL) begin
            hpm_scale = volt;
        end else begin
            hpm_scale = p[14:7];
        end
    endfunction : hpm_scale

    // duty fraction of the last measured period, 0..255
    function automatic logic [7:0] hpm_duty(input logic [CNT_W-1:0] hi,
                                            input logic [CNT_W-1:0] per);
        logic [CNT_W+7:0] r;
        r = '0;
        if (per != '0) begin
            r = {hi, 8'h00} / {8'h00, per};
        end
        if (r > (CNT_W+8)'(8'hFF)) begin
            hpm_duty = 8'hFF;
        end else begin
            hpm_duty = r[7:0];
        end
    endfunction : hpm_duty

    logic [2:0] eff_mode;
    logic stream_mode;
    logic trig_wr;
    logic pin_rise;
    logic start_req;
    logic play_done;
    logic [7:0] req_code;
    logic [7:0] req_mag;
    logic req_neg;
    logic [7:0] neg_code;

    always_comb begin
        // unknown codes fall back to inactive
        eff_mode = (q_r.mode > MODE_EDGE_MEM) ? MODE_INACTIVE : q_r.mode;
        stream_mode = (eff_mode == MODE_REG_STREAM) || (eff_mode == MODE_PWM_STREAM);
        trig_wr = i_wr && (i_addr == ADDR_TRIGGER) && i_wdata[TRIG_SEQ_BIT];
        pin_rise = q_r.pin_s2 && !q_r.pin_q;
        start_req = !i_fault && (stream_mode
            || (eff_mode == MODE_WRITE_MEM && trig_wr)
            || (eff_mode == MODE_EDGE_MEM && (trig_wr || pin_rise)));
        play_done = q_r.mem_active ? i_playback_done : !stream_mode;

        // requested level code, in the signed or unsigned sense set by accel
        req_code = 8'h00;
        case (eff_mode)
            MODE_REG_STREAM: req_code = q_r.stream;
            MODE_PWM_STREAM: begin
                if (q_r.duty < q_r.min_duty) begin
                    req_code = 8'h00;
                end else if (q_r.accel) begin
                    req_code = {1'b0, q_r.duty[7:1]};
                end else begin
                    req_code = q_r.duty ^ CODE_SIGN;
                end
            end
            MODE_WRITE_MEM, MODE_EDGE_MEM: req_code = i_mem_level;
            default: req_code = 8'h00;
        endcase
        neg_code = 8'(~req_code + 8'h01);
        if (q_r.accel) begin
            // upper half is unused and drives nothing
            req_neg = 1'b0;
            req_mag = req_code[7] ? 8'h00 : hpm_scale(req_code, q_r.nommax);
        end else begin
            req_neg = req_code[7];
            req_mag = hpm_scale(req_code[7] ? neg_code : req_code, q_r.absmax);
        end
        if (req_mag == 8'h00) begin
            req_neg = 1'b0;
        end
    end

    always_comb begin
        q_nxt = q_r;
        q_nxt.mem_start = 1'b0;
        q_nxt.rdata = 8'h00;

        q_nxt.pin_s1 = i_trigger_stream_pin;
        q_nxt.pin_s2 = q_r.pin_s1;
        q_nxt.pin_q = q_r.pin_s2;

        // register port, served in every state
        if (i_wr) begin
            case (i_addr)
                ADDR_CTRL: begin
                    q_nxt.mode = i_wdata[CTRL_MODE_LSB +: 3];
                    q_nxt.accel = i_wdata[CTRL_ACCEL_BIT];
                    q_nxt.standby = i_wdata[CTRL_STANDBY_BIT];
                    q_nxt.lra = i_wdata[CTRL_LRA_BIT];
                end
                ADDR_STREAM: q_nxt.stream = i_wdata;
                ADDR_NOMMAX: q_nxt.nommax = i_wdata;
                ADDR_ABSMAX: q_nxt.absmax = i_wdata;
                ADDR_MIN_DUTY: q_nxt.min_duty = i_wdata;
                default: q_nxt.stream = q_r.stream;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                ADDR_CTRL: q_nxt.rdata = {2'h0, q_r.lra, q_r.standby, q_r.accel, q_r.mode};
                ADDR_STREAM: q_nxt.rdata = q_r.stream;
                ADDR_NOMMAX: q_nxt.rdata = q_r.nommax;
                ADDR_ABSMAX: q_nxt.rdata = q_r.absmax;
                ADDR_MIN_DUTY: q_nxt.rdata = q_r.min_duty;
                ADDR_STATUS: q_nxt.rdata = {3'h0, q_r.en_pend, q_r.stage_en,
                                            q_r.half_pol, q_r.fsm};
                ADDR_LEVEL: q_nxt.rdata = q_r.app_mag;
                ADDR_DUTY: q_nxt.rdata = q_r.duty;
                default: q_nxt.rdata = 8'h00;
            endcase
        end

        // duty demodulator: a period runs from one rising edge to the next
        if (pin_rise) begin
            q_nxt.duty = hpm_duty(q_r.hi_cnt, q_r.per_cnt);
            q_nxt.per_cnt = (CNT_W)'(1);
            q_nxt.hi_cnt = (CNT_W)'(1);
        end else if (q_r.per_cnt == CNT_MAX) begin
            // no edges: pin is static, so duty is 0 or 100 percent
            q_nxt.duty = q_r.pin_s2 ? 8'hFF : 8'h00;
            q_nxt.hi_cnt = '0;
        end else begin
            q_nxt.per_cnt = q_r.per_cnt + (CNT_W)'(1);
            if (q_r.pin_s2) begin
                q_nxt.hi_cnt = q_r.hi_cnt + (CNT_W)'(1);
            end
        end

        // bridge strobe is free running, unrelated to the input pwm rate
        // the counter keeps running with the stage off, so no restart is needed on re-enable
        q_nxt.br_tick = 1'b0;
        if (q_r.br_cnt == BR_LAST) begin
            q_nxt.br_cnt = 9'h000;
            q_nxt.br_tick = q_r.stage_en;
        end else begin
            q_nxt.br_cnt = q_r.br_cnt + 9'h001;
        end

        // system states
        case (q_r.fsm)
            HPM_BOOT: begin
                if (i_boot_done) begin
                    q_nxt.fsm = HPM_IDLE;
                end
            end
            HPM_IDLE, HPM_STANDBY: begin
                if (start_req) begin
                    q_nxt.fsm = HPM_DRIVE;
                    q_nxt.mem_active = !stream_mode;
                    q_nxt.mem_start = !stream_mode;
                end
            end
            HPM_DRIVE: begin
                if (play_done) begin
                    q_nxt.fsm = q_r.standby ? HPM_STANDBY : HPM_IDLE;
                    q_nxt.mem_active = 1'b0;
                end
            end
            default: q_nxt.fsm = HPM_IDLE;
        endcase
        if (i_fault && q_r.fsm != HPM_BOOT) begin
            q_nxt.fsm = HPM_IDLE;
            q_nxt.mem_active = 1'b0;
            q_nxt.mem_start = 1'b0;
        end

        // amplitude path: sampled only around zero crossings
        if (q_r.fsm != HPM_DRIVE) begin
            q_nxt.app_mag = 8'h00;
            q_nxt.app_neg = 1'b0;
            q_nxt.stage_en = 1'b0;
            q_nxt.en_pend = 1'b0;
        end else if (i_zero_cross) begin
            q_nxt.half_pol = !q_r.half_pol;
            if (req_mag == 8'h00) begin
                // holding zero: stage off to save power
                q_nxt.app_mag = 8'h00;
                q_nxt.app_neg = 1'b0;
                q_nxt.stage_en = 1'b0;
                q_nxt.en_pend = 1'b0;
            end else if (!q_r.stage_en && !q_r.en_pend) begin
                q_nxt.en_pend = 1'b1;
            end else begin
                q_nxt.stage_en = 1'b1;
                q_nxt.en_pend = 1'b0;
                q_nxt.app_mag = req_mag;
                q_nxt.app_neg = req_neg;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q_r <= '0;
            q_r.fsm <= HPM_BOOT;
            q_r.mode <= RST_MODE;
            q_r.stream <= RST_STREAM;
            q_r.nommax <= RST_NOMMAX;
            q_r.absmax <= RST_ABSMAX;
            q_r.min_duty <= RST_MIN_DUTY;
        end else if (i_ce) begin
            q_r <= q_nxt;
        end
    end

    assign o_rdata = q_r.rdata;
    assign o_state = q_r.fsm;
    assign o_drive_mag = q_r.app_mag;
    assign o_drive_reverse = q_r.app_neg;
    assign o_stage_en = q_r.stage_en;
    assign o_bridge_tick = q_r.br_tick;
    assign o_half_pol = q_r.half_pol;
    assign o_mem_start = q_r.mem_start;

    default clocking hpm_cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    boot_exit_a: assert property (
        q_r.fsm == HPM_BOOT && i_boot_done && i_ce |=> o_state == HPM_IDLE)
        else $error("boot did not end in idle");
    fault_idle_a: assert property (
        q_r.fsm != HPM_BOOT && i_fault && i_ce |=> o_state == HPM_IDLE)
        else $error("fault did not force idle");
    stream_start_a: assert property (
        (q_r.fsm == HPM_IDLE || q_r.fsm == HPM_STANDBY) && stream_mode && !i_fault && i_ce
        |=> o_state == HPM_DRIVE)
        else $error("streaming mode did not enter drive");
    done_return_a: assert property (
        q_r.fsm == HPM_DRIVE && play_done && !i_fault && i_ce
        |=> (o_state == HPM_STANDBY) == $past(q_r.standby) && o_state != HPM_DRIVE)
        else $error("wrong state after playback end");
    bad_mode_a: assert property (
        (q_r.fsm == HPM_IDLE || q_r.fsm == HPM_STANDBY) && q_r.mode > MODE_EDGE_MEM && i_ce
        |=> o_state != HPM_DRIVE)
        else $error("undefined mode started playback");
    zero_cross_a: assert property (
        q_r.fsm == HPM_DRIVE && !(i_zero_cross && i_ce) |=> $stable(o_drive_mag))
        else $error("level changed away from a zero cross");
    reenable_half_a: assert property (
        q_r.fsm == HPM_DRIVE && !q_r.stage_en && !q_r.en_pend && req_mag != 8'h00
        && i_zero_cross && i_ce && !i_fault
        |=> !o_stage_en ##0 q_r.en_pend)
        else $error("stage enabled without half-period delay");
    stage_off_a: assert property (
        q_r.fsm != HPM_DRIVE && $past(q_r.fsm) != HPM_DRIVE |-> !o_stage_en && o_drive_mag == 8'h00)
        else $error("stage active outside drive");
    status_read_a: assert property (
        i_rd && i_addr == ADDR_STATUS && i_ce |=> o_rdata[1:0] == $past(q_r.fsm))
        else $error("status read returned wrong state");
    min_duty_a: assert property (
        eff_mode == MODE_PWM_STREAM && q_r.duty < q_r.min_duty |-> req_mag == 8'h00)
        else $error("duty below threshold gave drive");
    mem_start_a: assert property (
        (q_r.fsm == HPM_IDLE || q_r.fsm == HPM_STANDBY) && eff_mode == MODE_WRITE_MEM
        && trig_wr && !i_fault && i_ce |=> o_mem_start && o_state == HPM_DRIVE)
        else $error("trigger write did not start memory playback");
    half_toggle_a: assert property (
        q_r.fsm == HPM_DRIVE && i_zero_cross && i_ce |=> o_half_pol != $past(q_r.half_pol))
        else $error("polarity indication did not toggle");
    bridge_quiet_a: assert property (
        !q_r.stage_en && i_ce |=> !o_bridge_tick)
        else $error("bridge strobe while stage off");

    reg_drive_c: cover property (q_r.fsm == HPM_IDLE ##1 q_r.fsm == HPM_DRIVE
        && eff_mode == MODE_REG_STREAM);
    pwm_drive_c: cover property (q_r.fsm == HPM_DRIVE && eff_mode == MODE_PWM_STREAM
        && q_r.stage_en);
    standby_c: cover property (q_r.fsm == HPM_DRIVE ##1 q_r.fsm == HPM_STANDBY);
    reverse_c: cover property (q_r.app_neg && q_r.stage_en);
    edge_start_c: cover property (eff_mode == MODE_EDGE_MEM && pin_rise && q_r.fsm != HPM_DRIVE);
endmodule : hpm_ctrl

// ### rtl/hpm_pkg.sv
/*
 * hpm_pkg: constants, register map and state type shared by the haptic playback
 * and mode control block.
 * Assumes a single 50 MHz system clock and an 8-bit plain register port.
 */
package hpm_pkg;
    localparam int REG_AW = 4;
    localparam int REG_DW = 8;

    // register offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STREAM = 4'h1;
    localparam logic [3:0] ADDR_NOMMAX = 4'h2;
    localparam logic [3:0] ADDR_ABSMAX = 4'h3;
    localparam logic [3:0] ADDR_MIN_DUTY = 4'h4;
    localparam logic [3:0] ADDR_TRIGGER = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_LEVEL = 4'h7;
    localparam logic [3:0] ADDR_DUTY = 4'h8;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACCEL_BIT = 3;
    localparam int CTRL_STANDBY_BIT = 4;
    localparam int CTRL_LRA_BIT = 5;
    localparam int TRIG_SEQ_BIT = 0;

    // reset values
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic [7:0] RST_STREAM = 8'h00;
    localparam logic [7:0] RST_NOMMAX = 8'hFF;
    localparam logic [7:0] RST_ABSMAX = 8'hFF;
    localparam logic [7:0] RST_MIN_DUTY = 8'h00;

    // playback modes
    localparam logic [2:0] MODE_INACTIVE = 3'h0;
    localparam logic [2:0] MODE_REG_STREAM = 3'h1;
    localparam logic [2:0] MODE_PWM_STREAM = 3'h2;
    localparam logic [2:0] MODE_WRITE_MEM = 3'h3;
    localparam logic [2:0] MODE_EDGE_MEM = 3'h4;

    // level codes
    localparam logic [7:0] CODE_FULL = 8'h7F;
    localparam logic [7:0] CODE_SIGN = 8'h80;

    // timing
    localparam int CLK_HZ = 50000000;
    localparam int BRIDGE_FREQ_DHZ = 1875000; // 187.5 kHz in tenths of a hertz
    localparam int BRIDGE_DIV = (CLK_HZ * 10) / BRIDGE_FREQ_DHZ;

    typedef enum logic [1:0] {
        HPM_BOOT = 2'h0,
        HPM_IDLE = 2'h1,
        HPM_DRIVE = 2'h3,
        HPM_STANDBY = 2'h2
    } hpm_state_t;
endpackage : hpm_pkg
